// ===== verilog/cpu_regs_pkg.sv
// constants and types shared by the register and stacking unit
package cpu_regs_pkg;

	// ****************************************************************
	// clock and cycle-clock timing
	// ****************************************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int E_HZ = 100_000;
	localparam int E_HALF_CYC = CLK_HZ / (2 * E_HZ);

	// ****************************************************************
	// stack pointer layout
	// ****************************************************************
	localparam logic [6:0] SP_FIXED_HI = 7'h03;
	localparam logic [11:0] SP_RESET = 12'h07f;
	localparam logic [11:0] SP_FLOOR = 12'h061;
	localparam int NEST_LEVELS = 15;

	// ****************************************************************
	// condition flags and reset values
	// ****************************************************************
	localparam int CC_H = 4;
	localparam int CC_I = 3;
	localparam int CC_N = 2;
	localparam int CC_Z = 1;
	localparam int CC_C = 0;
	localparam logic [4:0] CC_RESET = 5'h08;
	localparam logic [2:0] CC_PAD = 3'h7;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [7:0] IDX_RESET = 8'h00;
	localparam logic [11:0] PC_RESET = 12'h000;

	typedef enum logic [3:0] {
		ALU_ADD = 4'h0,
		ALU_ADC = 4'h1,
		ALU_SUB = 4'h2,
		ALU_SBC = 4'h3,
		ALU_AND = 4'h4,
		ALU_ORA = 4'h5,
		ALU_EOR = 4'h6,
		ALU_LSL = 4'h7,
		ALU_LSR = 4'h8,
		ALU_ROL = 4'h9,
		ALU_ROR = 4'ha,
		ALU_INC = 4'hb,
		ALU_DEC = 4'hc,
		ALU_COM = 4'hd,
		ALU_NEG = 4'he,
		ALU_TST = 4'hf
	} alu_op_t;

	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_PUSH_PCL = 4'h1,
		S_PUSH_PCH = 4'h2,
		S_PUSH_X = 4'h3,
		S_PUSH_A = 4'h4,
		S_PUSH_CC = 4'h5,
		S_PULL_CC = 4'h6,
		S_PULL_A = 4'h7,
		S_PULL_X = 4'h8,
		S_PULL_PCH = 4'h9,
		S_PULL_PCL = 4'ha
	} seq_t;

	typedef enum logic [2:0] {
		CAP_CC = 3'h0,
		CAP_A = 3'h1,
		CAP_X = 3'h2,
		CAP_PCH = 3'h3,
		CAP_PCL = 3'h4
	} cap_t;

endpackage

// ===== verilog/pin_sync.sv
// two-flop synchroniser with falling-edge detect for active-low pins
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] fell
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
	} sync_t;

	sync_t q;
	sync_t d;

	// s1 feeds s2 only; the edge compare uses s2 and s3
	always_comb begin
		d = q;
		d.s1 = pin;
		d.s2 = q.s1;
		d.s3 = q.s2;
	end

	// pins idle high, so reset to high avoids a false edge
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '1;
		end else begin
			q <= d;
		end
	end

	assign level = q.s2;
	assign fell = q.s3 & ~q.s2;

endmodule // pin_sync

// ===== verilog/alu_flags.sv
// arithmetic and logic unit with flag results
`timescale 1ns/1ps
module alu_flags
	import cpu_regs_pkg::*;
(
	input wire alu_op_t op,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic c_in,
	output logic [7:0] res,
	output logic h_out,
	output logic c_out,
	output logic upd_h,
	output logic upd_c
);

	logic [8:0] wide;
	logic [4:0] nib;
	logic cy;

	// separate add and subtract paths; subtract forms give borrow as carry out
	always_comb begin
		wide = 9'h000;
		nib = 5'h00;
		cy = (op == ALU_ADC || op == ALU_SBC) ? c_in : 1'h0;
		res = 8'h00;
		c_out = 1'h0;
		h_out = 1'h0;
		upd_h = 1'h0;
		upd_c = 1'h0;
		case (op)
			ALU_ADD, ALU_ADC: begin
				wide = {1'h0, a} + {1'h0, b} + {8'h00, cy};
				nib = {1'h0, a[3:0]} + {1'h0, b[3:0]} + {4'h0, cy};
				res = wide[7:0];
				c_out = wide[8];
				h_out = nib[4];
				upd_h = 1'h1;
				upd_c = 1'h1;
			end
			ALU_SUB, ALU_SBC: begin
				wide = {1'h0, a} - {1'h0, b} - {8'h00, cy};
				res = wide[7:0];
				c_out = wide[8];
				upd_c = 1'h1;
			end
			ALU_AND: res = a & b;
			ALU_ORA: res = a | b;
			ALU_EOR: res = a ^ b;
			ALU_LSL: begin
				res = {a[6:0], 1'h0};
				c_out = a[7];
				upd_c = 1'h1;
			end
			ALU_LSR: begin
				res = {1'h0, a[7:1]};
				c_out = a[0];
				upd_c = 1'h1;
			end
			ALU_ROL: begin
				res = {a[6:0], c_in};
				c_out = a[7];
				upd_c = 1'h1;
			end
			ALU_ROR: begin
				res = {c_in, a[7:1]};
				c_out = a[0];
				upd_c = 1'h1;
			end
			ALU_INC: res = a + 8'h01;
			ALU_DEC: res = a - 8'h01;
			ALU_COM: begin
				res = ~a;
				c_out = 1'h1;
				upd_c = 1'h1;
			end
			ALU_NEG: begin
				res = 8'h00 - a;
				c_out = (a != 8'h00);
				upd_c = 1'h1;
			end
			ALU_TST: res = a;
			default: res = a;
		endcase
	end

endmodule // alu_flags

// ===== verilog/cpu_reg_stack.sv
// programmer-visible registers, stacking sequencer and cycle clock
//
// What this block does
// - interrupt stacks pc low byte, then high bits
// - subroutine call stacks only the two pc parts
// - stack pointer: next free, post-decrement, pre-increment
// - stack pointer twelve bits, top seven fixed
// - reset and reload instruction set pointer to 07F
// - stack reaches down to 061, fifteen levels
// - program counter is twelve bit next address
// - accumulator is eight bit operand and result
// - indexed address is index plus offset
// - four condition flags (H, N, Z, C) reflect last result; I is the mask
// - add operations set half carry from bit three
// - masked requests stay pending until unmasked
// - unmask delays one instruction; mask acts immediately
// - negative flag copies result bit seven
// - zero flag set on all-zero result
// - carry from alu, bit tests, shifts, rotates
// - falling edge on interrupt pin requests interrupt
// - cycle clock toggles on e_oe_n_q (e_out_q tied low), low in halt, standby, reset
// - bit ops on write-only targets change nothing
`timescale 1ns/1ps
module cpu_reg_stack
	import cpu_regs_pkg::*;
#(
	parameter int E_HALF = E_HALF_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic int_n,
	input wire logic standby_n,
	input wire logic int_req,
	input wire logic halted,
	input wire logic instr_done,
	input wire logic pc_inc,
	input wire logic pc_load,
	input wire logic [11:0] pc_load_val,
	input wire logic acc_load,
	input wire logic idx_load,
	input wire logic [7:0] load_val,
	input wire logic alu_go,
	input wire alu_op_t alu_op,
	input wire logic alu_to_idx,
	input wire logic [7:0] alu_b,
	input wire logic bit_test_go,
	input wire logic bit_test_val,
	input wire logic reload_stack_instr,
	input wire logic mask_irq_instr,
	input wire logic unmask_irq_instr,
	input wire logic call_go,
	input wire logic [11:0] call_target,
	input wire logic ret_go,
	input wire logic rti_go,
	input wire logic bit_op_go,
	input wire logic bit_op_set,
	input wire logic [2:0] bit_op_bit,
	input wire logic [11:0] bit_op_addr,
	input wire logic [7:0] bit_op_data,
	input wire logic bit_op_wo,
	input wire logic ea_go,
	input wire logic [11:0] ea_offset,
	input wire logic [7:0] mem_rdata,
	output logic [7:0] acc_q,
	output logic [7:0] idx_q,
	output logic [11:0] pc_q,
	output logic [11:0] sp_q,
	output logic [4:0] cc_q,
	output logic [11:0] ea_q,
	output logic [11:0] mem_addr_q,
	output logic [7:0] mem_wdata_q,
	output logic mem_we_q,
	output logic mem_re_q,
	output logic busy_q,
	output logic irq_taken_q,
	output logic irq_pending_q,
	output logic stack_ovf_q,
	output logic e_out_q,
	output logic e_oe_n_q
);

	initial begin
		if (E_HALF < 1 || E_HALF > 255) $error("E_HALF must be 1..255");
		if ((int'(SP_RESET) - int'(SP_FLOOR) + 1) / 2 != NEST_LEVELS)
			$error("stack depth does not match nesting levels");
	end

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] idx;
		logic [11:0] pc;
		logic [4:0] sp_low;
		logic [4:0] cc;
		seq_t seq;
		cap_t cap;
		logic is_irq;
		logic [11:0] tgt;
		logic irq_pend;
		logic [11:0] ea;
		logic [11:0] mem_addr;
		logic [7:0] mem_wdata;
		logic mem_we;
		logic mem_re;
		logic busy;
		logic irq_taken;
		logic ovf;
		logic [7:0] ediv;
		logic e_lvl;
	} state_t;

	localparam state_t STATE_RESET = '{
		acc: ACC_RESET, idx: IDX_RESET, pc: PC_RESET,
		sp_low: SP_RESET[4:0], cc: CC_RESET,
		seq: S_IDLE, cap: CAP_CC, is_irq: 1'h0, tgt: 12'h000,
		irq_pend: 1'h0, ea: 12'h000, mem_addr: 12'h000,
		mem_wdata: 8'h00, mem_we: 1'h0, mem_re: 1'h0, busy: 1'h0,
		irq_taken: 1'h0, ovf: 1'h0, ediv: 8'h00, e_lvl: 1'h0
	};
	localparam logic [7:0] E_LAST = 8'(E_HALF - 1);

	state_t q;
	state_t d;

	logic [1:0] pin_lvl;
	logic [1:0] pin_fell;
	logic [7:0] alu_a;
	logic [7:0] alu_res;
	logic alu_h;
	logic alu_c;
	logic alu_uh;
	logic alu_uc;
	logic idle;
	logic grant;
	logic [11:0] sp_full;
	logic [7:0] bit_mask;

	// ****************************************************************
	// pin synchroniser and alu
	// ****************************************************************
	pin_sync #(.WIDTH(2)) u_sync (
		.clk(clk),
		.rst(rst),
		.pin({standby_n, int_n}),
		.level(pin_lvl),
		.fell(pin_fell)
	);

	assign alu_a = alu_to_idx ? q.idx : q.acc;

	alu_flags u_alu (
		.op(alu_op),
		.a(alu_a),
		.b(alu_b),
		.c_in(q.cc[CC_C]),
		.res(alu_res),
		.h_out(alu_h),
		.c_out(alu_c),
		.upd_h(alu_uh),
		.upd_c(alu_uc)
	);

	// helpers: full pointer, bit mask, interrupt grant at boundaries
	assign idle = (q.seq == S_IDLE);
	assign sp_full = {SP_FIXED_HI, q.sp_low};
	assign bit_mask = 8'h01 << bit_op_bit;
	// unmask this boundary still blocks; mask blocks at once
	assign grant = idle && instr_done && q.irq_pend && !q.cc[CC_I]
		&& !unmask_irq_instr && !mask_irq_instr;

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	always_comb begin
		d = q;
		d.mem_we = 1'h0;
		d.mem_re = 1'h0;
		d.irq_taken = 1'h0;
		// pulled byte is valid in the cycle its read strobe stands
		if (q.mem_re) begin
			case (q.cap)
				CAP_CC: d.cc = mem_rdata[4:0];
				CAP_A: d.acc = mem_rdata;
				CAP_X: d.idx = mem_rdata;
				CAP_PCH: d.pc[11:8] = mem_rdata[3:0];
				CAP_PCL: d.pc[7:0] = mem_rdata;
				default: d.pc = q.pc;
			endcase
		end
		case (q.seq)
			S_IDLE: begin
				if (grant) begin
					d.irq_pend = 1'h0;
					d.is_irq = 1'h1;
					d.seq = S_PUSH_PCL;
				end else if (call_go) begin
					d.is_irq = 1'h0;
					d.tgt = call_target;
					d.seq = S_PUSH_PCL;
				end else if (ret_go) begin
					d.seq = S_PULL_PCH;
				end else if (rti_go) begin
					d.seq = S_PULL_CC;
				end else begin
					if (pc_load) begin
						d.pc = pc_load_val;
					end else if (pc_inc) begin
						d.pc = q.pc + 12'h001;
					end
					if (acc_load) begin
						d.acc = load_val;
						d.cc[CC_N] = load_val[7];
						d.cc[CC_Z] = (load_val == 8'h00);
					end
					if (idx_load) begin
						d.idx = load_val;
						d.cc[CC_N] = load_val[7];
						d.cc[CC_Z] = (load_val == 8'h00);
					end
					if (alu_go) begin
						if (alu_to_idx) begin
							d.idx = alu_res;
						end else begin
							d.acc = alu_res;
						end
						d.cc[CC_N] = alu_res[7];
						d.cc[CC_Z] = (alu_res == 8'h00);
						if (alu_uh) d.cc[CC_H] = alu_h;
						if (alu_uc) d.cc[CC_C] = alu_c;
					end
					if (bit_test_go) d.cc[CC_C] = bit_test_val;
					if (reload_stack_instr) d.sp_low = SP_RESET[4:0];
					if (mask_irq_instr) d.cc[CC_I] = 1'h1;
					if (unmask_irq_instr) d.cc[CC_I] = 1'h0;
					// write-only targets get no write at all
					if (bit_op_go && !bit_op_wo) begin
						d.mem_addr = bit_op_addr;
						d.mem_wdata = bit_op_set ? (bit_op_data | bit_mask)
							: (bit_op_data & ~bit_mask);
						d.mem_we = 1'h1;
					end
					if (ea_go) d.ea = ea_offset + {4'h0, q.idx};
				end
			end
			S_PUSH_PCL, S_PUSH_PCH, S_PUSH_X, S_PUSH_A, S_PUSH_CC: begin
				// write at the free slot, then step down
				d.mem_addr = sp_full;
				d.mem_we = 1'h1;
				d.sp_low = q.sp_low - 5'h01;
				if (sp_full < SP_FLOOR) d.ovf = 1'h1;
				case (q.seq)
					S_PUSH_PCL: begin
						d.mem_wdata = q.pc[7:0];
						d.seq = S_PUSH_PCH;
					end
					S_PUSH_PCH: begin
						d.mem_wdata = {4'h0, q.pc[11:8]};
						d.seq = q.is_irq ? S_PUSH_X : S_IDLE;
						if (!q.is_irq) d.pc = q.tgt;
					end
					S_PUSH_X: begin
						d.mem_wdata = q.idx;
						d.seq = S_PUSH_A;
					end
					S_PUSH_A: begin
						d.mem_wdata = q.acc;
						d.seq = S_PUSH_CC;
					end
					default: begin
						d.mem_wdata = {CC_PAD, q.cc};
						d.cc[CC_I] = 1'h1;
						d.irq_taken = 1'h1;
						d.seq = S_IDLE;
					end
				endcase
			end
			S_PULL_CC, S_PULL_A, S_PULL_X, S_PULL_PCH, S_PULL_PCL: begin
				// step up first, then read the slot it lands on
				d.sp_low = q.sp_low + 5'h01;
				d.mem_addr = {SP_FIXED_HI, q.sp_low + 5'h01};
				d.mem_re = 1'h1;
				case (q.seq)
					S_PULL_CC: begin
						d.cap = CAP_CC;
						d.seq = S_PULL_A;
					end
					S_PULL_A: begin
						d.cap = CAP_A;
						d.seq = S_PULL_X;
					end
					S_PULL_X: begin
						d.cap = CAP_X;
						d.seq = S_PULL_PCH;
					end
					S_PULL_PCH: begin
						d.cap = CAP_PCH;
						d.seq = S_PULL_PCL;
					end
					default: begin
						d.cap = CAP_PCL;
						d.seq = S_IDLE;
					end
				endcase
			end
			default: d.seq = S_IDLE;
		endcase
		// a new request in the clearing cycle is kept
		if (pin_fell[0] || int_req) d.irq_pend = 1'h1;
		d.busy = (d.seq != S_IDLE) || d.mem_re;
		// cycle clock stops low so the pin idles driven low
		if (halted || !pin_lvl[1]) begin
			d.ediv = 8'h00;
			d.e_lvl = 1'h0;
		end else if (q.ediv == E_LAST) begin
			d.ediv = 8'h00;
			d.e_lvl = ~q.e_lvl;
		end else begin
			d.ediv = q.ediv + 8'h01;
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= STATE_RESET;
		end else begin
			q <= d;
		end
	end

	assign acc_q = q.acc;
	assign idx_q = q.idx;
	assign pc_q = q.pc;
	assign sp_q = sp_full;
	assign cc_q = q.cc;
	assign ea_q = q.ea;
	assign mem_addr_q = q.mem_addr;
	assign mem_wdata_q = q.mem_wdata;
	assign mem_we_q = q.mem_we;
	assign mem_re_q = q.mem_re;
	assign busy_q = q.busy;
	assign irq_taken_q = q.irq_taken;
	assign irq_pending_q = q.irq_pend;
	assign stack_ovf_q = q.ovf;
	assign e_out_q = 1'h0;
	assign e_oe_n_q = q.e_lvl;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic push_now;
	logic call_ok;
	assign push_now = (q.seq >= S_PUSH_PCL) && (q.seq <= S_PUSH_CC);
	assign call_ok = idle && !grant && call_go;

	property p_irq_pc_order;
		grant |-> ##2 (mem_we_q && mem_wdata_q == $past(pc_q[7:0], 2))
			##1 (mem_we_q && mem_wdata_q[3:0] == $past(pc_q[11:8], 3));
	endproperty
	a_irq_pc_order: assert property (p_irq_pc_order) else $error("pc stacking order");

	property p_call_two;
		call_ok |-> ##4 (sp_q[4:0] == $past(sp_q[4:0], 4) - 5'h02);
	endproperty
	a_call_two: assert property (p_call_two) else $error("call pushed wrong count");

	property p_push_step;
		push_now |=> (mem_we_q && mem_addr_q == $past(sp_q)
			&& sp_q[4:0] == $past(sp_q[4:0]) - 5'h01);
	endproperty
	a_push_step: assert property (p_push_step) else $error("push pointer step");

	property p_sp_hi;
		sp_q[11:5] == 7'h03;
	endproperty
	a_sp_hi: assert property (p_sp_hi) else $error("pointer top bits moved");

	property p_reload;
		(idle && !grant && !call_go && !ret_go && !rti_go && reload_stack_instr)
			|=> sp_q == 12'h07f;
	endproperty
	a_reload: assert property (p_reload) else $error("reload did not set 07f");

	property p_ovf;
		(push_now && sp_q < 12'h061) |=> stack_ovf_q;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow not flagged");

	property p_ea;
		(idle && !grant && !call_go && !ret_go && !rti_go && ea_go)
			|=> ea_q == $past(ea_offset) + {4'h0, $past(idx_q)};
	endproperty
	a_ea: assert property (p_ea) else $error("indexed address wrong");

	property p_nz;
		(idle && !grant && !call_go && !ret_go && !rti_go && alu_go && !alu_to_idx)
			|=> (cc_q[2] == acc_q[7] && cc_q[1] == (acc_q == 8'h00));
	endproperty
	a_nz: assert property (p_nz) else $error("n or z flag wrong");

	property p_unmask_hold;
		(idle && unmask_irq_instr && instr_done && !call_go && !ret_go && !rti_go)
			|-> ##1 !busy_q ##1 !mem_we_q;
	endproperty
	a_unmask_hold: assert property (p_unmask_hold) else $error("irq right after unmask");

	property p_masked;
		// a call taken at a masked boundary is legal, so only idle boundaries count
		(idle && instr_done && cc_q[3] && !call_go && !ret_go && !rti_go) |=> !busy_q;
	endproperty
	a_masked: assert property (p_masked) else $error("masked irq serviced");

	property p_irq_regs;
		grant |-> ##4 (mem_wdata_q == $past(idx_q, 4)) ##1 (mem_wdata_q == $past(acc_q, 5))
			##1 (mem_wdata_q[4:0] == $past(cc_q, 6) && irq_taken_q);
	endproperty
	a_irq_regs: assert property (p_irq_regs) else $error("register stacking order");

	property p_e_halt;
		halted |=> (e_oe_n_q == 1'h0);
	endproperty
	a_e_halt: assert property (p_e_halt) else $error("cycle clock not low in halt");

	c_irq_entry: cover property (irq_taken_q);
	c_call_ret: cover property (call_ok ##[4:20] (idle && ret_go));
	c_rti: cover property (idle && rti_go);
	c_ovf: cover property ($rose(stack_ovf_q));

endmodule // cpu_reg_stack

// ===== testbench/tb_cpu_reg_stack.sv
// self-checking bench for the register and stacking unit
`timescale 1ns/1ps
module tb_cpu_reg_stack import cpu_regs_pkg::*;;
	logic clk = 1'b0, rst = 1'b1, int_n = 1'b1, standby_n = 1'b1, int_req = 1'b0, halted = 1'b0;
	logic instr_done = 1'b0, pc_inc = 1'b0, pc_load = 1'b0, acc_load = 1'b0, idx_load = 1'b0;
	logic alu_go = 1'b0, alu_to_idx = 1'b0, bit_test_go = 1'b0, bit_test_val = 1'b0;
	logic reload_stack_instr = 1'b0, mask_irq_instr = 1'b0, unmask_irq_instr = 1'b0;
	logic call_go = 1'b0, ret_go = 1'b0, rti_go = 1'b0, bit_op_go = 1'b0, bit_op_set = 1'b0;
	logic bit_op_wo = 1'b0, ea_go = 1'b0;
	logic [2:0] bit_op_bit = 3'h0;
	logic [7:0] load_val = 8'h00, alu_b = 8'h00, bit_op_data = 8'h00, mem_rdata;
	logic [11:0] pc_load_val = 12'h000, call_target = 12'h000, bit_op_addr = 12'h000;
	logic [11:0] ea_offset = 12'h000, pc_q, sp_q, ea_q, mem_addr_q;
	alu_op_t alu_op = ALU_ADD;
	logic [7:0] acc_q, idx_q, mem_wdata_q;
	logic [4:0] cc_q;
	logic mem_we_q, mem_re_q, busy_q, irq_taken_q, irq_pending_q, stack_ovf_q, e_out_q, e_oe_n_q;
	logic [7:0] mem [4096];
	logic [11:0] wa[$], pcs[$];
	logic [7:0] wd[$];
	logic [7:0] m_a = 8'h00, m_x = 8'h00, sv_a, sv_x, r;
	logic [11:0] m_pc = 12'h000, m_sp = 12'h07f, sv_pc;
	logic [4:0] sv_cc;
	logic m_h = 1'b0, m_i = 1'b1, m_n = 1'b0, m_z = 1'b0, m_c = 1'b0;
	int error_cnt = 0, cmp_count = 0, taken_cnt = 0, re_cnt = 0, seed, n;

	// short cycle-clock half period keeps the toggle test brief
	cpu_reg_stack #(.E_HALF(2)) cpu_reg_stack_inst (.clk(clk), .rst(rst), .int_n(int_n),
		.standby_n(standby_n), .int_req(int_req), .halted(halted), .instr_done(instr_done),
		.pc_inc(pc_inc), .pc_load(pc_load), .pc_load_val(pc_load_val), .acc_load(acc_load),
		.idx_load(idx_load), .load_val(load_val), .alu_go(alu_go), .alu_op(alu_op),
		.alu_to_idx(alu_to_idx), .alu_b(alu_b), .bit_test_go(bit_test_go),
		.bit_test_val(bit_test_val), .reload_stack_instr(reload_stack_instr),
		.mask_irq_instr(mask_irq_instr), .unmask_irq_instr(unmask_irq_instr),
		.call_go(call_go), .call_target(call_target), .ret_go(ret_go), .rti_go(rti_go),
		.bit_op_go(bit_op_go), .bit_op_set(bit_op_set), .bit_op_bit(bit_op_bit),
		.bit_op_addr(bit_op_addr), .bit_op_data(bit_op_data), .bit_op_wo(bit_op_wo),
		.ea_go(ea_go), .ea_offset(ea_offset), .mem_rdata(mem_rdata), .acc_q(acc_q),
		.idx_q(idx_q), .pc_q(pc_q), .sp_q(sp_q), .cc_q(cc_q), .ea_q(ea_q),
		.mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_we_q(mem_we_q),
		.mem_re_q(mem_re_q), .busy_q(busy_q), .irq_taken_q(irq_taken_q),
		.irq_pending_q(irq_pending_q), .stack_ovf_q(stack_ovf_q), .e_out_q(e_out_q),
		.e_oe_n_q(e_oe_n_q));

	// 100 ns clock
	always #50 clk = ~clk;

	// combinational memory answers reads in the strobe cycle
	assign mem_rdata = mem[mem_addr_q];

	// record every stack or bit-op write, count read strobes and irq_taken pulses
	always @(posedge clk) begin
		if (mem_we_q === 1'b1) begin
			mem[mem_addr_q] <= mem_wdata_q;
			wa.push_back(mem_addr_q);
			wd.push_back(mem_wdata_q);
		end
		if (irq_taken_q === 1'b1) taken_cnt++;
		if (mem_re_q === 1'b1) re_cnt++;
	end

	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// bounded wait for a stack sequence to finish; a hang counts as a mismatch
	task automatic idle_wait();
		repeat (2) @(negedge clk);
		n = 0;
		while (busy_q !== 1'b0 && n < 40) begin
			@(negedge clk);
			n++;
		end
		// the last write lands with busy low; one more edge lets the log see it
		@(negedge clk);
		check(16'(n < 40), 16'h1);
	endtask

	function automatic logic [4:0] ccx();
		return {m_h, m_i, m_n, m_z, m_c};
	endfunction

	task automatic load(input logic to_idx, input logic [7:0] v);
		load_val = v;
		acc_load = ~to_idx;
		idx_load = to_idx;
		@(negedge clk);
		acc_load = 1'b0;
		idx_load = 1'b0;
		if (to_idx) m_x = v;
		else m_a = v;
		m_n = v[7];
		m_z = (v == 8'h00);
		check(to_idx ? idx_q : acc_q, v);
		check(cc_q, ccx());
	endtask

	task automatic alu_step(input alu_op_t op, input logic [7:0] b);
		int s;
		s = (op == ALU_SUB) ? int'(m_a) - int'(b) : int'(m_a) + int'(b);
		if (op == ALU_ADC) s = s + int'(m_c);
		if (op != ALU_SUB) m_h = ((m_a & 15) + (b & 15) + ((op == ALU_ADC) ? m_c : 0)) > 15;
		m_c = (op == ALU_SUB) ? (m_a < b) : (s > 255);
		r = s[7:0];
		alu_op = op;
		alu_b = b;
		alu_go = 1'b1;
		@(negedge clk);
		alu_go = 1'b0;
		m_a = r;
		m_n = r[7];
		m_z = (r == 8'h00);
		check(acc_q, m_a);
		check(cc_q, ccx());
	endtask

	task automatic do_call(input logic [11:0] t);
		wa.delete();
		wd.delete();
		call_target = t;
		call_go = 1'b1;
		@(negedge clk);
		call_go = 1'b0;
		idle_wait();
		check(16'(wa.size()), 16'h2);
		check(wa[0], m_sp);
		check(wd[0], m_pc[7:0]);
		check(wa[1], {SP_FIXED_HI, m_sp[4:0] - 5'd1});
		check(wd[1], {4'h0, m_pc[11:8]});
		pcs.push_back(m_pc);
		m_pc = t;
		m_sp = {SP_FIXED_HI, m_sp[4:0] - 5'd2};
		check(pc_q, m_pc);
		check(sp_q, m_sp);
	endtask

	// one-cycle strobe helper for the mask and boundary controls
	task automatic strobe(input logic msk, input logic unm, input logic done);
		mask_irq_instr = msk;
		unmask_irq_instr = unm;
		instr_done = done;
		@(negedge clk);
		mask_irq_instr = 1'b0;
		unmask_irq_instr = 1'b0;
		instr_done = 1'b0;
	endtask

	// watchdog far beyond the expected run of about three hundred cycles
	initial begin
		#2_000_000;
		error_cnt++;
		conclude();
	end

	// ****************************************************************
	// test sequence
	// ****************************************************************
	initial begin
		seed = $urandom(32'h8cd6);
		repeat (16) @(negedge clk);
		check({acc_q, idx_q}, 16'h0000);
		check(sp_q, SP_RESET);
		check(pc_q, PC_RESET);
		check(cc_q, CC_RESET);
		check(e_oe_n_q, 1'b0);
		check(e_out_q, 1'b0);
		rst = 1'b0;
		@(negedge clk);
		$display("test reset done, errors %0d", error_cnt);
		load(1'b0, 8'h0f);
		alu_step(ALU_ADD, 8'h01);
		load(1'b0, 8'hff);
		alu_step(ALU_ADD, 8'h01);
		for (int k = 0; k < 12; k++) begin
			if (k % 4 == 0) load(1'b0, 8'($urandom));
			alu_step((k % 3 == 0) ? ALU_ADD : (k % 3 == 1) ? ALU_ADC : ALU_SUB, 8'($urandom));
		end
		for (int k = 0; k < 2; k++) begin
			bit_test_val = ~m_c;
			bit_test_go = 1'b1;
			@(negedge clk);
			bit_test_go = 1'b0;
			m_c = ~m_c;
			check(cc_q, ccx());
		end
		$display("test alu done, errors %0d", error_cnt);
		for (int k = 0; k < 4; k++) begin
			load(1'b1, 8'($urandom));
			ea_offset = 12'($urandom);
			ea_go = 1'b1;
			@(negedge clk);
			ea_go = 1'b0;
			check(ea_q, 12'(ea_offset + {4'h0, m_x}));
		end
		pc_load_val = 12'hfff;
		pc_load = 1'b1;
		@(negedge clk);
		pc_load = 1'b0;
		pc_inc = 1'b1;
		@(negedge clk);
		pc_inc = 1'b0;
		m_pc = 12'h000;
		check(pc_q, m_pc);
		do_call(12'($urandom));
		ret_go = 1'b1;
		@(negedge clk);
		ret_go = 1'b0;
		idle_wait();
		m_pc = pcs.pop_back();
		m_sp = SP_RESET;
		check(pc_q, m_pc);
		check(sp_q, m_sp);
		check(16'(re_cnt), 16'h2);
		$display("test call done, errors %0d", error_cnt);
		// masked external request, then both mask timings, then grant
		strobe(1'b0, 1'b1, 1'b0);
		m_i = 1'b0;
		check(cc_q, ccx());
		int_n = 1'b0;
		repeat (6) @(negedge clk);
		check(irq_pending_q, 1'b1);
		wa.delete();
		wd.delete();
		strobe(1'b1, 1'b0, 1'b1);
		m_i = 1'b1;
		strobe(1'b0, 1'b0, 1'b1);
		check(irq_pending_q, 1'b1);
		strobe(1'b0, 1'b1, 1'b1);
		m_i = 1'b0;
		repeat (3) @(negedge clk);
		check(16'(wa.size()), 16'h0);
		{sv_cc, sv_a, sv_x, sv_pc} = {ccx(), m_a, m_x, m_pc};
		strobe(1'b0, 1'b0, 1'b1);
		idle_wait();
		check(16'(wa.size()), 16'h5);
		for (int k = 0; k < 5; k++) check(wa[k], 12'h07f - 12'(k));
		check(wd[0], sv_pc[7:0]);
		check(wd[1], {4'h0, sv_pc[11:8]});
		check({wd[2], wd[3]}, {sv_x, sv_a});
		check(wd[4], {CC_PAD, sv_cc});
		check(16'(taken_cnt), 16'h1);
		check(sp_q, 12'h07a);
		check({cc_q[3], irq_pending_q}, 2'b10);
		int_n = 1'b1;
		rti_go = 1'b1;
		@(negedge clk);
		rti_go = 1'b0;
		idle_wait();
		check(cc_q, sv_cc);
		check({acc_q, idx_q}, {sv_a, sv_x});
		check(pc_q, sv_pc);
		check(sp_q, SP_RESET);
		check(16'(re_cnt), 16'h7);
		// internal request: no boundary follows, so it must stay pending
		int_req = 1'b1;
		@(negedge clk);
		int_req = 1'b0;
		@(negedge clk);
		check(irq_pending_q, 1'b1);
		$display("test interrupt done, errors %0d", error_cnt);
		for (int k = 0; k < NEST_LEVELS; k++) do_call(12'($urandom));
		check({stack_ovf_q, sp_q}, {1'b0, SP_FLOOR});
		reload_stack_instr = 1'b1;
		@(negedge clk);
		reload_stack_instr = 1'b0;
		m_sp = SP_RESET;
		check(sp_q, SP_RESET);
		for (int k = 0; k <= NEST_LEVELS; k++) do_call(12'($urandom));
		check(stack_ovf_q, 1'b1);
		$display("test nesting done, errors %0d", error_cnt);
		for (int k = 0; k < 4; k++) begin
			wa.delete();
			wd.delete();
			{bit_op_wo, bit_op_set} = 2'(k);
			bit_op_bit = 3'($urandom);
			bit_op_data = 8'($urandom);
			bit_op_addr = 12'($urandom);
			bit_op_go = 1'b1;
			@(negedge clk);
			bit_op_go = 1'b0;
			repeat (2) @(negedge clk);
			r = bit_op_set ? (bit_op_data | (8'h01 << bit_op_bit)) :
				(bit_op_data & ~(8'h01 << bit_op_bit));
			check(16'(wa.size()), {15'h0, ~bit_op_wo});
			if (!bit_op_wo) check({wa[0], wd[0]}, {bit_op_addr, r});
		end
		$display("test bit ops done, errors %0d", error_cnt);
		// toggles every two clocks: forty samples see exactly twenty changes
		n = 0;
		for (int k = 0; k < 40; k++) begin
			r[0] = e_oe_n_q;
			@(negedge clk);
			if (e_oe_n_q !== r[0]) n++;
		end
		check(16'(n), 16'd20);
		for (int k = 0; k < 2; k++) begin
			halted = (k == 0);
			standby_n = (k == 0);
			repeat (4) @(negedge clk);
			n = 0;
			repeat (20) begin
				@(negedge clk);
				if (e_oe_n_q !== 1'b0) n++;
			end
			check(16'(n), 16'h0);
			{halted, standby_n} = 2'b01;
		end
		$display("test cycle clock done, errors %0d", error_cnt);
		conclude();
	end
endmodule // tb_cpu_reg_stack
